// ==== pmc_pkg.sv ====
package pmc_pkg;
	// management frame field widths and port count
	localparam int PHYAD_W = 5;
	localparam int REGAD_W = 5;
	localparam int DATA_W  = 16;
	localparam int NPORTS  = 5;

	// port address window
	localparam logic [4:0] PHYAD_FIRST = 5'h01;
	localparam logic [4:0] PHYAD_LAST  = 5'h05;

	// supported register addresses
	localparam logic [4:0] REG_CTRL    = 5'h00;
	localparam logic [4:0] REG_STATUS  = 5'h01;
	localparam logic [4:0] REG_LAST_LO = 5'h05;
	localparam logic [4:0] REG_1D      = 5'h1d;
	localparam logic [4:0] REG_1F      = 5'h1f;

	// control and status register bit positions
	localparam int CB_RESET    = 15;
	localparam int CB_LOOPBACK = 14;
	localparam int CB_SPEED100 = 13;
	localparam int CB_AN_EN    = 12;
	localparam int CB_PWRDN    = 11;
	localparam int CB_ISOLATE  = 10;
	localparam int CB_AN_RST   = 9;
	localparam int CB_FULLDUP  = 8;
	localparam int SB_LINK     = 2;

	// reset values and write mask
	localparam logic [15:0] CTRL_RESET   = 16'h3000;
	localparam logic [15:0] CTRL_WR_MASK = 16'hff00;
	localparam logic [15:0] STATUS_FIXED = 16'h7808;

	// spi map: port p at base SPI_BASE + 0x20*(p-1), register at offset
	localparam logic [7:0] SPI_BASE = 8'h20;

	// soft reset duration in clock cycles
	localparam int SRST_CYCLES = 16;

	// frame lengths after preamble
	localparam int FRAME_BITS = 32;

	typedef struct packed {
		logic       wr;
		logic [4:0] port;    // 1..5
		logic [4:0] regad;
		logic [15:0] wdata;
	} pmc_req_t;

	typedef struct packed {
		logic speed100;
		logic an_en;
		logic pwrdn;
		logic isolate;
		logic fulldup;
		logic loopback;
	} pmc_ctl_t;
endpackage : pmc_pkg

// ==== pmc_port_regs.sv ====
`timescale 1ns/10ps
module pmc_port_regs (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// access
	input  wire logic              we_i,
	input  wire logic [4:0]        regad_i,
	input  wire logic [15:0]       wdata_i,
	input  wire logic              link_up_i,
	output logic      [15:0]       rdata_o,
	// port controls
	output pmc_pkg::pmc_ctl_t      ctl_o,
	output logic                   soft_reset_o,
	output logic                   an_restart_o
);
	typedef struct packed {
		logic [15:0] ctrl;
		logic [4:0]  srst_cnt;
		logic        an_pulse;
	} pmc_preg_t;

	pmc_preg_t st_reg, st_next;

	// control register write, self clearing bits
	always_comb begin
		st_next = st_reg;
		st_next.an_pulse = 1'b0;
		if (st_reg.srst_cnt != 5'h00) begin
			st_next.srst_cnt = st_reg.srst_cnt - 5'h01;
			if (st_reg.srst_cnt == 5'h01) begin
				st_next.ctrl = pmc_pkg::CTRL_RESET;
			end
		end
		if (we_i && regad_i == pmc_pkg::REG_CTRL) begin
			st_next.ctrl = wdata_i & pmc_pkg::CTRL_WR_MASK;
			st_next.ctrl[pmc_pkg::CB_AN_RST] = 1'b0;
			if (wdata_i[pmc_pkg::CB_AN_RST]) begin
				st_next.an_pulse = 1'b1;
			end
			if (wdata_i[pmc_pkg::CB_RESET]) begin
				st_next.srst_cnt = 5'(pmc_pkg::SRST_CYCLES);
			end else begin
				st_next.ctrl[pmc_pkg::CB_RESET] = st_reg.ctrl[pmc_pkg::CB_RESET];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '{ctrl: pmc_pkg::CTRL_RESET, srst_cnt: 5'h00, an_pulse: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// read mux and controls
	always_comb begin
		rdata_o = 16'h0000;
		case (regad_i)
			pmc_pkg::REG_CTRL:   rdata_o = st_reg.ctrl;
			pmc_pkg::REG_STATUS: begin
				rdata_o = pmc_pkg::STATUS_FIXED;
				rdata_o[pmc_pkg::SB_LINK] = link_up_i;
			end
			default:             rdata_o = 16'h0000;
		endcase
	end

	assign ctl_o.loopback = st_reg.ctrl[pmc_pkg::CB_LOOPBACK];
	assign ctl_o.speed100 = st_reg.ctrl[pmc_pkg::CB_SPEED100];
	assign ctl_o.an_en    = st_reg.ctrl[pmc_pkg::CB_AN_EN];
	assign ctl_o.pwrdn    = st_reg.ctrl[pmc_pkg::CB_PWRDN];
	assign ctl_o.isolate  = st_reg.ctrl[pmc_pkg::CB_ISOLATE];
	assign ctl_o.fulldup  = st_reg.ctrl[pmc_pkg::CB_FULLDUP];
	assign soft_reset_o   = st_reg.ctrl[pmc_pkg::CB_RESET];
	assign an_restart_o   = st_reg.an_pulse;

	a_reset_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(st_reg.srst_cnt != 5'h00) |-> !st_reg.ctrl[pmc_pkg::CB_RESET])
		else $error("soft reset bit did not clear");
	a_restart_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		an_restart_o |=> !an_restart_o || $past(we_i))
		else $error("restart pulse too long");

	// control write that starts a soft reset
	sequence s_srst_write;
		we_i && regad_i == pmc_pkg::REG_CTRL && wdata_i[pmc_pkg::CB_RESET];
	endsequence

	// soft reset duration and values after reset
	a_srst_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		s_srst_write |=> soft_reset_o [*8])
		else $error("soft reset bit dropped early");
	a_reset_values: assert property (@(posedge clk_i)
		$fell(rst_i) |-> ctl_o.speed100 && ctl_o.an_en && !ctl_o.pwrdn
			&& !ctl_o.isolate && !ctl_o.fulldup && !soft_reset_o)
		else $error("control bits wrong after reset");
endmodule : pmc_port_regs

// ==== pmc_phy_mgmt.sv ====
`timescale 1ns/10ps
// Behaviour
// - phy address 1..5 selects ports 1..5
// - only registers 0..5, 0x1d, 0x1f exist
// - same registers reachable over spi map
// - soft reset bit self clears when done
// - loopback bit enables mac loopback
// - speed bit picks 100 or 10
// - autoneg enable bit, resets to one
// - power down bit, resets to zero
// - isolation bit, resets to zero
// - autoneg restart bit pulses restart
// - duplex bit picks full or half
// - status bit 2 shows link up
module pmc_phy_mgmt (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// phy management interface pins
	input  wire logic                 mdc_i,
	input  wire logic                 mdio_i,
	output logic                      mdio_o,
	output logic                      mdio_oe_o,
	// spi side register access, same clock
	input  wire logic                 spi_req_i,
	input  wire logic                 spi_wr_i,
	input  wire logic [7:0]           spi_addr_i,
	input  wire logic [15:0]          spi_wdata_i,
	output logic      [15:0]          spi_rdata_o,
	// port status and controls
	input  wire logic [4:0]           link_up_i,
	output pmc_pkg::pmc_ctl_t [4:0]   port_ctl_o,
	output logic      [4:0]           soft_reset_o,
	output logic      [4:0]           an_restart_o
);
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_HDR  = 4'b0010,
		S_RD   = 4'b0100,
		S_WR   = 4'b1000
	} pmc_state_t;

	typedef struct packed {
		pmc_state_t  fsm;
		logic [2:0]  mdc_s;
		logic [1:0]  mdio_s;
		logic [5:0]  ones;
		logic [5:0]  cnt;
		logic [13:0] hdr;
		logic [15:0] sh;
		logic        oe;
		logic [15:0] spi_rd;
	} pmc_st_t;

	pmc_st_t st_reg, st_next;
	logic [4:0]       we;
	logic [15:0]      rd [5];
	logic             mdc_rise;
	logic             bit_in;
	pmc_pkg::pmc_req_t req;
	logic             req_v;
	logic [15:0]      rsel;

	// port decode of a phy address, 0 when outside the window
	function automatic logic [2:0] port_of(input logic [4:0] a);
		if (a >= pmc_pkg::PHYAD_FIRST && a <= pmc_pkg::PHYAD_LAST) begin
			port_of = 3'(a);
		end else begin
			port_of = 3'h0;
		end
	endfunction : port_of

	// register address supported check
	function automatic logic reg_ok(input logic [4:0] r);
		reg_ok = (r <= pmc_pkg::REG_LAST_LO) || (r == pmc_pkg::REG_1D)
			|| (r == pmc_pkg::REG_1F);
	endfunction : reg_ok

	assign mdc_rise = st_reg.mdc_s[1] & ~st_reg.mdc_s[2];
	assign bit_in   = st_reg.mdio_s[1];

	// access source: spi wins when both arrive in one cycle
	always_comb begin
		req   = '0;
		req_v = 1'b0;
		if (spi_req_i) begin
			req.wr    = spi_wr_i;
			req.port  = 5'({2'h0, spi_addr_i[7:5]} + 5'h01 - 5'(pmc_pkg::SPI_BASE >> 5));
			req.regad = spi_addr_i[4:0];
			req.wdata = spi_wdata_i;
			req_v     = spi_addr_i >= pmc_pkg::SPI_BASE;
		end else begin
			req.wr    = st_reg.fsm == S_WR && st_reg.cnt == 6'd16 && mdc_rise;
			req.port  = st_reg.hdr[9:5];
			req.regad = st_reg.hdr[4:0];
			req.wdata = {st_reg.sh[14:0], bit_in};
			req_v     = 1'b1;
		end
	end

	// per port register banks
	for (genvar p = 0; p < pmc_pkg::NPORTS; p++) begin : g_port
		assign we[p] = req_v && req.wr && reg_ok(req.regad)
			&& port_of(req.port) == 3'(p + 1);
		pmc_port_regs u_regs (
			.clk_i        (clk_i),
			.rst_i        (rst_i),
			.we_i         (we[p]),
			.regad_i      (req.regad),
			.wdata_i      (req.wdata),
			.link_up_i    (link_up_i[p]),
			.rdata_o      (rd[p]),
			.ctl_o        (port_ctl_o[p]),
			.soft_reset_o (soft_reset_o[p]),
			.an_restart_o (an_restart_o[p])
		);
	end

	// read select, zero for unmapped addresses
	always_comb begin
		rsel = 16'h0000;
		if (req_v && reg_ok(req.regad) && port_of(req.port) != 3'h0) begin
			rsel = rd[port_of(req.port) - 3'h1];
		end
	end

	// management frame engine, sampled on mdc rising edges
	always_comb begin
		st_next        = st_reg;
		st_next.mdc_s  = {st_reg.mdc_s[1:0], mdc_i};
		st_next.mdio_s = {st_reg.mdio_s[0], mdio_i};
		if (spi_req_i && !spi_wr_i) begin
			st_next.spi_rd = rsel;
		end
		if (mdc_rise) begin
			case (st_reg.fsm)
				S_IDLE: begin
					st_next.ones = bit_in ? ((st_reg.ones == 6'd32) ? 6'd32
						: st_reg.ones + 6'd1) : 6'd0;
					if (!bit_in && st_reg.ones == 6'd32) begin
						st_next.fsm = S_HDR;
						st_next.cnt = 6'd0;
						st_next.hdr = 14'h0000;
					end
				end
				S_HDR: begin
					// first turnaround bit is not shifted in, so hdr[9:5] stays the address
					if (st_reg.cnt != 6'd13) begin
						st_next.hdr = {st_reg.hdr[12:0], bit_in};
					end
					st_next.cnt = st_reg.cnt + 6'd1;
					if (st_reg.cnt == 6'd13) begin
						st_next.cnt = 6'd0;
						st_next.ones = 6'd0;
						if (st_reg.hdr[12] == 1'b1 && st_reg.hdr[11:10] == 2'b10) begin
							st_next.fsm = S_RD;
							st_next.oe  = 1'b1;               // drive the turnaround zero
							st_next.sh  = 16'h0000;
						end else if (st_reg.hdr[12] == 1'b1
							&& st_reg.hdr[11:10] == 2'b01) begin
							st_next.fsm = S_WR;
						end else begin
							st_next.fsm = S_IDLE;
						end
					end
				end
				S_RD: begin
					st_next.cnt = st_reg.cnt + 6'd1;
					if (st_reg.cnt == 6'd0) begin
						st_next.sh = rsel;                    // msb out before the host samples
					end else begin
						st_next.sh = {st_reg.sh[14:0], 1'b0};
					end
					if (st_reg.cnt == 6'd16) begin
						st_next.oe  = 1'b0;                   // release after the last data bit
						st_next.fsm = S_IDLE;
					end
				end
				S_WR: begin
					st_next.cnt = st_reg.cnt + 6'd1;
					if (st_reg.cnt >= 6'd1) begin
						st_next.sh = {st_reg.sh[14:0], bit_in};
					end
					if (st_reg.cnt == 6'd16) begin
						st_next.fsm = S_IDLE;
					end
				end
				default: st_next.fsm = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '{fsm: S_IDLE, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign mdio_o      = st_reg.sh[15];
	assign mdio_oe_o   = st_reg.oe;
	assign spi_rdata_o = st_reg.spi_rd;

	// read header complete: turnaround zero follows on the next cycle
	sequence s_rd_header;
		mdc_rise && st_reg.fsm == S_HDR && st_reg.cnt == 6'd13
			&& st_reg.hdr[12:10] == 3'b110;
	endsequence

	// last read data bit has been clocked out
	sequence s_rd_last;
		mdc_rise && st_reg.fsm == S_RD && st_reg.cnt == 6'd16;
	endsequence

	// frame engine and unmapped access checks
	a_turn_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rd_header |=> mdio_oe_o && !mdio_o)
		else $error("turnaround zero not driven");
	a_oe_release: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rd_last |=> !mdio_oe_o)
		else $error("data line not released after read");
	a_low_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		spi_req_i && !spi_wr_i && spi_addr_i < pmc_pkg::SPI_BASE
			|=> spi_rdata_o == 16'h0000)
		else $error("unmapped spi read not zero");
	a_high_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
		spi_req_i && spi_wr_i && spi_addr_i >= 8'hc0 |-> we == 5'h00)
		else $error("unmapped spi write reached a port");
endmodule : pmc_phy_mgmt

// ==== pmc_mdio_host.sv ====
`timescale 1ns/10ps
module pmc_mdio_host (
	// management pins seen from the host
	output logic      mdc_o,
	output logic      mdio_o,
	input  wire logic mdio_i,
	input  wire logic mdio_oe_i
);
	logic drv;
	logic hdat;
	// shared line: pull-up wins when nobody drives
	assign mdio_o = mdio_oe_i ? mdio_i : (drv ? hdat : 1'b1);
	initial begin
		mdc_o = 1'b0;
		drv = 1'b0;
		hdat = 1'b1;
	end
	// one bit: data set while clock low, line sampled at the rise
	task automatic bit_cyc(input logic b, input logic en, output logic s);
		mdc_o = 1'b0;
		drv = en;
		hdat = b;
		#100;
		s = mdio_o;
		mdc_o = 1'b1;
		#100;
	endtask : bit_cyc
	// whole frame; clock stands low outside it, line released on turnaround of a read only
	task automatic frame(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] f;
		logic        s;
		f = {32'hffffffff, 2'b01, wr ? 2'b01 : 2'b10, pa, ra, 2'b10, wd};
		#7;
		for (int i = 63; i >= 0; i--) begin
			bit_cyc(f[i], wr || i > 17, s);
			if (i < 16) rd[i] = s;
		end
		mdc_o = 1'b0;
		drv = 1'b0;
	endtask : frame
endmodule : pmc_mdio_host

// ==== tb_pmc_phy_mgmt.sv ====
`timescale 1ns/10ps
module tb_pmc_phy_mgmt;
	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	logic                    mdc, mdio_in, mdio_out, mdio_oe;
	logic                    spi_req = 1'b0;
	logic                    spi_wr = 1'b0;
	logic [7:0]              spi_addr = 8'h00;
	logic [15:0]             spi_wdata = 16'h0000;
	logic [15:0]             spi_rdata, rd;
	logic [4:0]              link_up = 5'h00;
	logic [4:0]              srst, anr;
	pmc_pkg::pmc_ctl_t [4:0] ctl;
	int                      n_fail = 0;
	int                      n_checks = 0;
	int                      n_srst = 0;
	int                      n_anr = 0;
	// clock and pulse-length counters
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		n_srst += int'(srst[1] === 1'b1);
		n_anr += int'(anr[2] === 1'b1);
	end
	pmc_phy_mgmt dut_u (.clk_i(clk), .rst_i(rst), .mdc_i(mdc), .mdio_i(mdio_in),
		.mdio_o(mdio_out), .mdio_oe_o(mdio_oe), .spi_req_i(spi_req), .spi_wr_i(spi_wr),
		.spi_addr_i(spi_addr), .spi_wdata_i(spi_wdata), .spi_rdata_o(spi_rdata),
		.link_up_i(link_up), .port_ctl_o(ctl), .soft_reset_o(srst), .an_restart_o(anr));
	pmc_mdio_host host_u (.mdc_o(mdc), .mdio_o(mdio_in), .mdio_i(mdio_out), .mdio_oe_i(mdio_oe));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one register access; read data taken once it has settled
	task automatic spi(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		spi_req = 1'b1;
		spi_wr = wr;
		spi_addr = a;
		spi_wdata = d;
		@(negedge clk);
		spi_req = 1'b0;
		@(negedge clk);
		rd = spi_rdata;
	endtask : spi
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	// main sequence
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		link_up = 5'h15;
		repeat (2) @(negedge clk);
		for (int p = 1; p <= 5; p++) begin
			spi(1'b0, 8'(p * 32), 16'h0000);
			chk("ctrl reset", 16'h3000, rd);
			spi(1'b0, 8'(p * 32 + 1), 16'h0000);
			chk("status", 16'h7808 | (16'(link_up[p-1]) << 2), rd);
		end
		chk("ctl reset", 16'h0030, 16'(ctl[0]));
		$display("test reset done");
		spi(1'b1, 8'h60, 16'h4d00);
		spi(1'b0, 8'h60, 16'h0000);
		chk("ctrl bits", 16'h4d00, rd);
		chk("ctl bits", 16'h000f, 16'(ctl[2]));
		chk("ctl other", 16'h0030, 16'(ctl[1]));
		n_anr = 0;
		spi(1'b1, 8'h60, 16'h3200);
		spi(1'b0, 8'h60, 16'h0000);
		chk("restart rd", 16'h3000, rd);
		chk("restart pulse", 16'h0001, 16'(n_anr));
		$display("test control done");
		n_srst = 0;
		spi(1'b1, 8'h40, 16'hb000);
		repeat (24) @(negedge clk);
		spi(1'b0, 8'h40, 16'h0000);
		chk("srst bit", 16'h0000, rd & 16'h8000);
		chk("srst len", 16'(pmc_pkg::SRST_CYCLES), 16'(n_srst));
		$display("test soft reset done");
		for (int i = 0; i < 4; i++) begin
			spi(1'b1, i[1] ? 8'h26 + 8'(i[0]) * 8'h17 : 8'hc0 * 8'(i[0]), 16'hffff);
			spi(1'b0, i[1] ? 8'h26 + 8'(i[0]) * 8'h17 : 8'hc0 * 8'(i[0]), 16'h0000);
			chk("unmapped", 16'h0000, rd);
		end
		chk("ctl kept", 16'h0030, 16'(ctl[0]));
		$display("test unmapped done");
		host_u.frame(1'b1, 5'h05, 5'h00, 16'h2100, rd);
		host_u.frame(1'b0, 5'h05, 5'h00, 16'h0000, rd);
		chk("mdio ctrl", 16'h2100, rd);
		chk("ctl mdio", 16'h0022, 16'(ctl[4]));
		spi(1'b0, 8'ha0, 16'h0000);
		chk("spi view", 16'h2100, rd);
		host_u.frame(1'b0, 5'h01, 5'h01, 16'h0000, rd);
		chk("mdio status", 16'h780c, rd);
		$display("test mdio done");
		end_of_test();
	end
	// watchdog well beyond the expected run length
	initial begin
		#300000;
		n_fail++;
		end_of_test();
	end
endmodule : tb_pmc_phy_mgmt
